/* pkg/cffr_pkg.sv */
`default_nettype none

package cffr_pkg;

  // bus geometry
  localparam int unsigned CFFR_DATA_W = 32;
  localparam int unsigned CFFR_ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] CFFR_OFS_FUNC_SEL = 8'h00;
  localparam logic [7:0] CFFR_OFS_ISSUE    = 8'h04;
  localparam logic [7:0] CFFR_OFS_FLAGS_D  = 8'h08;
  localparam logic [7:0] CFFR_OFS_FLAGS_C  = 8'h0C;
  localparam logic [7:0] CFFR_OFS_STATUS   = 8'h10;
  localparam logic [7:0] CFFR_OFS_COUNT    = 8'h14;

  // function code that returns the feature words
  localparam logic [31:0] CFFR_FUNC_FEATURES = 32'h00000001;

  // bit positions in feature_flags_d
  localparam int unsigned CFFR_D_PACKED_INT_BIT = 23;
  localparam int unsigned CFFR_D_VEC1_BIT       = 25;
  localparam int unsigned CFFR_D_VEC2_BIT       = 26;

  // bit positions in feature_flags_c
  localparam int unsigned CFFR_C_VEC3_BIT       = 0;
  localparam int unsigned CFFR_C_MON_WAIT_BIT   = 3;
  localparam int unsigned CFFR_C_VEC3_SUPP_BIT  = 9;
  localparam int unsigned CFFR_C_VEC4_1_BIT     = 19;
  localparam int unsigned CFFR_C_VEC4_2_BIT     = 20;

  // status register fields
  localparam int unsigned CFFR_STAT_VALID_BIT     = 0;
  localparam int unsigned CFFR_STAT_SUPPORTED_BIT = 1;
  localparam int unsigned CFFR_STAT_PENDING_BIT   = 2;
  localparam int unsigned CFFR_STAT_SW_SRC_BIT    = 3;

  // reset values
  localparam logic [31:0] CFFR_FUNC_SEL_RST = 32'h00000000;
  localparam logic [31:0] CFFR_FLAGS_RST    = 32'h00000000;
  localparam logic [31:0] CFFR_COUNT_RST    = 32'h00000000;
  localparam logic [31:0] CFFR_RDATA_RST    = 32'h00000000;

  // software issue tracker
  typedef enum logic [0:0] {
    CFFR_SW_IDLE = 1'b0,
    CFFR_SW_PEND = 1'b1
  } cffr_sw_e;

endpackage

`default_nettype wire

/* pkg/cffr_reg_if.sv */
`timescale 1ns/1ps
`default_nettype none

// register access path between the bus slave and the flag logic
interface cffr_reg_if;
  import cffr_pkg::*;
  logic [CFFR_ADDR_W-1:0] addr;
  logic [CFFR_DATA_W-1:0] wdata;
  logic                   wr_en;
  logic [CFFR_DATA_W-1:0] rdata;
  logic                   addr_ok;

  modport slave_side (output addr, output wdata, output wr_en, input rdata, input addr_ok);
  modport regs_side  (input addr, input wdata, input wr_en, output rdata, output addr_ok);
endinterface

`default_nettype wire

/* core/cffr_apb_slave.sv */
`timescale 1ns/1ps
`default_nettype none

module cffr_apb_slave
  import cffr_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [CFFR_ADDR_W-1:0] paddr_in,
  input  wire logic [CFFR_DATA_W-1:0] pwdata_in,
  output logic      [CFFR_DATA_W-1:0] prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  cffr_reg_if.slave_side              regs
);

  logic                   pready_q;
  logic                   pslverr_q;
  logic [CFFR_DATA_W-1:0] prdata_q;
  logic                   setup;

  assign setup = psel_in & ~penable_in;

  // address and data go straight to the register file
  assign regs.addr  = paddr_in;
  assign regs.wdata = pwdata_in;
  assign regs.wr_en = psel_in & penable_in & pready_q & pwrite_in & regs.addr_ok;

  // ready rises after the setup cycle, so every access has no wait state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  // read data and error are captured with the address of the setup cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_q  <= CFFR_RDATA_RST;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= (!pwrite_in && regs.addr_ok) ? regs.rdata : CFFR_RDATA_RST;
      pslverr_q <= ~regs.addr_ok; // unmapped address
    end else begin
      prdata_q  <= CFFR_RDATA_RST;
      pslverr_q <= 1'b0;
    end
  end

  assign prdata_out  = prdata_q;
  assign pready_out  = pready_q;
  assign pslverr_out = pslverr_q;

endmodule

`default_nettype wire

/* core/cffr_flag_rom.sv */
`timescale 1ns/1ps
`default_nettype none

module cffr_flag_rom
  import cffr_pkg::*;
#(
  parameter logic [CFFR_DATA_W-1:0] PRESENT_D = 32'h00000000,
  parameter logic [CFFR_DATA_W-1:0] PRESENT_C = 32'h00000000
) (
  input  wire logic [CFFR_DATA_W-1:0] func_in,
  output logic      [CFFR_DATA_W-1:0] flags_d_out,
  output logic      [CFFR_DATA_W-1:0] flags_c_out,
  output logic                        supported_out
);

  // only the feature function returns flags; any other code returns zero words
  assign supported_out = (func_in == CFFR_FUNC_FEATURES);

  // each flag bit is its fixed presence value gated by the function match
  for (genvar i = 0; i < CFFR_DATA_W; i++) begin : g_bit
    assign flags_d_out[i] = supported_out & PRESENT_D[i];
    assign flags_c_out[i] = supported_out & PRESENT_C[i];
  end

endmodule

`default_nettype wire

/* core/cffr_feature_report.sv */
// Function
// - A query with function code 1 returns the two feature-flag words in feature_flags_d and feature_flags_c.
// - Under function 1, feature_flags_d bit 23 is 1 only if the packed-integer multimedia extension is built in.
// - Under function 1, feature_flags_d bit 25 is 1 exactly when the first streaming vector extension is built in.
// - Under function 1, feature_flags_d bit 26 is 1 exactly when the second streaming vector extension is built in.
// - Under function 1, feature_flags_c bit 0 is 1 exactly when the third streaming vector extension is built in.
// - Under function 1, feature_flags_c bit 3 is 1 exactly when the monitor and monitored wait pair is present.
`timescale 1ns/1ps
`default_nettype none

module cffr_feature_report
  import cffr_pkg::*;
#(
  parameter bit HAS_PACKED_INT = 1'b1,
  parameter bit HAS_VEC1       = 1'b1,
  parameter bit HAS_VEC2       = 1'b1,
  parameter bit HAS_VEC3       = 1'b1,
  parameter bit HAS_MON_WAIT   = 1'b1,
  parameter bit HAS_VEC3_SUPP  = 1'b1,
  parameter bit HAS_VEC4_1     = 1'b1,
  parameter bit HAS_VEC4_2     = 1'b1
) (
  input  wire logic                   CLK_SYS_IN,
  input  wire logic                   SYS_RST_IN,
  input  wire logic                   PSEL_IN,
  input  wire logic                   PENABLE_IN,
  input  wire logic                   PWRITE_IN,
  input  wire logic [CFFR_ADDR_W-1:0] PADDR_IN,
  input  wire logic [CFFR_DATA_W-1:0] PWDATA_IN,
  output logic      [CFFR_DATA_W-1:0] PRDATA_OUT,
  output logic                        PREADY_OUT,
  output logic                        PSLVERR_OUT,
  input  wire logic                   QUERY_VALID_IN,
  input  wire logic [CFFR_DATA_W-1:0] QUERY_FUNC_IN,
  output logic                        ANSWER_VALID_OUT,
  output logic      [CFFR_DATA_W-1:0] FLAGS_D_OUT,
  output logic      [CFFR_DATA_W-1:0] FLAGS_C_OUT
);

  // fixed presence masks built from the build options
  localparam logic [31:0] PRESENT_D =
      ({31'h0, HAS_PACKED_INT} << CFFR_D_PACKED_INT_BIT)
    | ({31'h0, HAS_VEC1}       << CFFR_D_VEC1_BIT)
    | ({31'h0, HAS_VEC2}       << CFFR_D_VEC2_BIT);
  localparam logic [31:0] PRESENT_C =
      ({31'h0, HAS_VEC3}       << CFFR_C_VEC3_BIT)
    | ({31'h0, HAS_MON_WAIT}   << CFFR_C_MON_WAIT_BIT)
    | ({31'h0, HAS_VEC3_SUPP}  << CFFR_C_VEC3_SUPP_BIT)
    | ({31'h0, HAS_VEC4_1}     << CFFR_C_VEC4_1_BIT)
    | ({31'h0, HAS_VEC4_2}     << CFFR_C_VEC4_2_BIT);

  cffr_reg_if regs ();

  logic [CFFR_DATA_W-1:0] func_sel_q;
  logic [CFFR_DATA_W-1:0] flags_d_q;
  logic [CFFR_DATA_W-1:0] flags_c_q;
  logic [CFFR_DATA_W-1:0] count_q;
  logic                   answer_q;
  logic                   valid_q;
  logic                   supported_q;
  logic                   sw_src_q;
  cffr_sw_e               sw_q;
  cffr_sw_e               sw_d;

  logic [CFFR_DATA_W-1:0] rom_func;
  logic [CFFR_DATA_W-1:0] rom_flags_d;
  logic [CFFR_DATA_W-1:0] rom_flags_c;
  logic                   rom_supported;
  logic                   take_pipe;
  logic                   take_sw;
  logic                   take_any;
  logic                   wr_func_sel;
  logic                   wr_issue;
  logic [CFFR_DATA_W-1:0] status;

  // bus slave
  cffr_apb_slave u_apb (
    .clk_in      (CLK_SYS_IN),
    .rst_in      (SYS_RST_IN),
    .psel_in     (PSEL_IN),
    .penable_in  (PENABLE_IN),
    .pwrite_in   (PWRITE_IN),
    .paddr_in    (PADDR_IN),
    .pwdata_in   (PWDATA_IN),
    .prdata_out  (PRDATA_OUT),
    .pready_out  (PREADY_OUT),
    .pslverr_out (PSLVERR_OUT),
    .regs        (regs.slave_side)
  );

  // constant flag words per function
  cffr_flag_rom #(
    .PRESENT_D (PRESENT_D),
    .PRESENT_C (PRESENT_C)
  ) u_rom (
    .func_in       (rom_func),
    .flags_d_out   (rom_flags_d),
    .flags_c_out   (rom_flags_c),
    .supported_out (rom_supported)
  );

  // register write decode
  assign wr_func_sel = regs.wr_en & (regs.addr == CFFR_OFS_FUNC_SEL);
  assign wr_issue    = regs.wr_en & (regs.addr == CFFR_OFS_ISSUE);

  // pipeline queries win; a software query waits for a free cycle
  assign take_pipe = QUERY_VALID_IN;
  assign take_sw   = (sw_q == CFFR_SW_PEND) & ~QUERY_VALID_IN;
  assign take_any  = take_pipe | take_sw;
  assign rom_func  = take_pipe ? QUERY_FUNC_IN : func_sel_q;

  // software function-select register
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      func_sel_q <= CFFR_FUNC_SEL_RST;
    end else if (wr_func_sel) begin
      func_sel_q <= regs.wdata;
    end
  end

  // software issue tracker; a new issue in the taking cycle is kept
  always_comb begin
    sw_d = sw_q;
    unique case (sw_q)
      CFFR_SW_IDLE: begin
        if (wr_issue) begin
          sw_d = CFFR_SW_PEND;
        end
      end
      CFFR_SW_PEND: begin
        if (take_sw && !wr_issue) begin
          sw_d = CFFR_SW_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sw_q <= CFFR_SW_IDLE;
    end else begin
      sw_q <= sw_d;
    end
  end

  // result words load on every taken query
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      flags_d_q   <= CFFR_FLAGS_RST;
      flags_c_q   <= CFFR_FLAGS_RST;
      supported_q <= 1'b0;
      sw_src_q    <= 1'b0;
    end else if (take_any) begin
      flags_d_q   <= rom_flags_d;
      flags_c_q   <= rom_flags_c;
      supported_q <= rom_supported;
      sw_src_q    <= take_sw;
    end
  end

  // answer strobe to the pipeline, one cycle after its query
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      answer_q <= 1'b0;
    end else begin
      answer_q <= take_pipe;
    end
  end

  // query counter and result-valid flag
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      count_q <= CFFR_COUNT_RST;
      valid_q <= 1'b0;
    end else if (take_any) begin
      count_q <= count_q + 32'h00000001;
      valid_q <= 1'b1;
    end
  end

  // status word
  always_comb begin
    status                          = 32'h00000000;
    status[CFFR_STAT_VALID_BIT]     = valid_q;
    status[CFFR_STAT_SUPPORTED_BIT] = supported_q;
    status[CFFR_STAT_PENDING_BIT]   = (sw_q == CFFR_SW_PEND);
    status[CFFR_STAT_SW_SRC_BIT]    = sw_src_q;
  end

  // read mux and address map
  always_comb begin
    regs.rdata   = 32'h00000000;
    regs.addr_ok = 1'b1;
    unique case (regs.addr)
      CFFR_OFS_FUNC_SEL: regs.rdata = func_sel_q;
      CFFR_OFS_ISSUE:    regs.rdata = 32'h00000000;
      CFFR_OFS_FLAGS_D:  regs.rdata = flags_d_q;
      CFFR_OFS_FLAGS_C:  regs.rdata = flags_c_q;
      CFFR_OFS_STATUS:   regs.rdata = status;
      CFFR_OFS_COUNT:    regs.rdata = count_q;
      default:           regs.addr_ok = 1'b0;
    endcase
  end

  // outputs come straight from flip-flops
  assign ANSWER_VALID_OUT = answer_q;
  assign FLAGS_D_OUT      = flags_d_q;
  assign FLAGS_C_OUT      = flags_c_q;

endmodule

`default_nettype wire

/* verif/cffr_chk_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module cffr_chk_monitor
  import cffr_pkg::*;
(
  input wire logic                   CLK_SYS_IN,
  input wire logic                   SYS_RST_IN,
  input wire logic                   PSEL_IN,
  input wire logic                   PENABLE_IN,
  input wire logic [CFFR_ADDR_W-1:0] PADDR_IN,
  input wire logic                   PREADY_OUT,
  input wire logic                   PSLVERR_OUT,
  input wire logic                   QUERY_VALID_IN,
  input wire logic [CFFR_DATA_W-1:0] QUERY_FUNC_IN,
  input wire logic                   ANSWER_VALID_OUT,
  input wire logic [CFFR_DATA_W-1:0] FLAGS_D_OUT,
  input wire logic [CFFR_DATA_W-1:0] FLAGS_C_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);

  // pipeline queries split by function code
  sequence q_feat;
    QUERY_VALID_IN && QUERY_FUNC_IN == CFFR_FUNC_FEATURES;
  endsequence
  sequence q_other;
    QUERY_VALID_IN && QUERY_FUNC_IN != CFFR_FUNC_FEATURES;
  endsequence
  sequence bus_setup;
    PSEL_IN && !PENABLE_IN;
  endsequence

  chk_answer_follows: assert property (QUERY_VALID_IN |=> ANSWER_VALID_OUT)
    else $error("no answer after query");
  chk_answer_cause: assert property ($rose(ANSWER_VALID_OUT) |-> $past(QUERY_VALID_IN))
    else $error("answer without query");
  chk_other_zero: assert property (q_other |=> FLAGS_D_OUT == 32'h0 && FLAGS_C_OUT == 32'h0)
    else $error("other function not zero");
  chk_packed_int: assert property (q_feat |=> FLAGS_D_OUT[CFFR_D_PACKED_INT_BIT])
    else $error("packed int bit low");
  chk_d_word: assert property (q_feat |=> FLAGS_D_OUT == 32'h06800000)
    else $error("flags d word wrong");
  chk_vec3_bit: assert property (q_feat |=> FLAGS_C_OUT[CFFR_C_VEC3_BIT])
    else $error("vec3 bit low");
  chk_mon_wait: assert property (q_feat |=> FLAGS_C_OUT[CFFR_C_MON_WAIT_BIT])
    else $error("monitor wait bit low");
  chk_c_word: assert property (q_feat |=> FLAGS_C_OUT == 32'h00180209)
    else $error("flags c word wrong");
  chk_ready_pulse: assert property (bus_setup |=> PREADY_OUT ##1 !PREADY_OUT)
    else $error("ready not one cycle");
  chk_bad_addr: assert property (bus_setup ##0 (PADDR_IN[1:0] != 2'b00 || PADDR_IN > CFFR_OFS_COUNT) |=> PSLVERR_OUT)
    else $error("unmapped without error");
endmodule

bind cffr_feature_report cffr_chk_monitor i_chk (.CLK_SYS_IN, .SYS_RST_IN, .PSEL_IN, .PENABLE_IN,
  .PADDR_IN, .PREADY_OUT, .PSLVERR_OUT, .QUERY_VALID_IN, .QUERY_FUNC_IN, .ANSWER_VALID_OUT,
  .FLAGS_D_OUT, .FLAGS_C_OUT);

`default_nettype wire

/* verif/cffr_pipe_model.sv */
`timescale 1ns/1ps
`default_nettype none

module cffr_pipe_model
  import cffr_pkg::*;
(
  input  wire logic                   clk_in,
  output logic                        query_valid_out,
  output logic      [CFFR_DATA_W-1:0] query_func_out
);
  initial begin
    query_valid_out = 1'b0;
    query_func_out  = 32'h0;
  end

  // one query a call, entered just after an edge; last=0 keeps the strobe for a follower
  task automatic issue(input logic [CFFR_DATA_W-1:0] func, input bit last);
    query_valid_out <= 1'b1;
    query_func_out  <= func;
    @(posedge clk_in);
    if (last) begin
      query_valid_out <= 1'b0;
      query_func_out  <= ~func; // stale code must not look valid
    end
  endtask
endmodule

`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import cffr_pkg::*;
  typedef struct {logic [31:0] f; logic [31:0] d; logic [31:0] c; logic [31:0] st;} cffr_row_s;
  localparam logic [31:0] EXP_D = 32'h06800000;
  localparam logic [31:0] EXP_C = 32'h00180209;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, qv, ans, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, qf, d_out, c_out, r;
  int          n_mismatch = 0, n_tests = 0, cyc = 0, nq = 0;
  cffr_row_s   rows [5] = '{'{32'h1, EXP_D, EXP_C, 32'h3}, '{32'h0, 32'h0, 32'h0, 32'h1},
    '{32'h2, 32'h0, 32'h0, 32'h1}, '{32'h80000001, 32'h0, 32'h0, 32'h1}, '{32'h101, 32'h0, 32'h0, 32'h1}};

  cffr_feature_report i_dut (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .QUERY_VALID_IN(qv), .QUERY_FUNC_IN(qf), .ANSWER_VALID_OUT(ans),
    .FLAGS_D_OUT(d_out), .FLAGS_C_OUT(c_out));
  cffr_pipe_model i_pipe (.clk_in(clk), .query_valid_out(qv), .query_func_out(qf));

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    n_tests++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD %0t %s got %h want %h", $time, m, g, x);
    end
  endtask
  // one apb transfer, held until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // the wait ends when pready is seen high at an edge, or else at the cycle watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x, "register read");
    chk({31'h0, e}, 32'h0, "mapped read error");
  endtask
  task automatic tally_and_finish();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk(d_out | c_out, 32'h0, "reset flags");
    rdchk(CFFR_OFS_STATUS, 32'h0);
    rdchk(CFFR_OFS_COUNT, 32'h0);
    $display("reset test done");
    // table of pipeline queries
    foreach (rows[i]) begin
      @(posedge clk);
      i_pipe.issue(rows[i].f, 1'b1);
      nq++;
      @(negedge clk);
      chk({31'h0, ans}, 32'h1, "answer strobe");
      chk(d_out, rows[i].d, "flags d out");
      chk(c_out, rows[i].c, "flags c out");
      rdchk(CFFR_OFS_FLAGS_D, rows[i].d);
      rdchk(CFFR_OFS_FLAGS_C, rows[i].c);
      rdchk(CFFR_OFS_STATUS, rows[i].st);
    end
    $display("table test done");
    // software query, then read-only and unmapped accesses
    apb(1'b1, CFFR_OFS_FUNC_SEL, 32'h1);
    apb(1'b1, CFFR_OFS_ISSUE, 32'h0);
    nq++;
    rdchk(CFFR_OFS_FUNC_SEL, 32'h1);
    rdchk(CFFR_OFS_ISSUE, 32'h0);
    rdchk(CFFR_OFS_STATUS, 32'hB);
    chk(d_out, EXP_D, "sw flags d");
    apb(1'b1, CFFR_OFS_FLAGS_C, 32'hFFFFFFFF);
    rdchk(CFFR_OFS_FLAGS_C, EXP_C);
    apb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0, "unmapped read data");
    chk({31'h0, e}, 32'h1, "unmapped read error");
    apb(1'b0, 8'h05, 32'h0);
    chk({31'h0, e}, 32'h1, "unaligned read error");
    $display("software test done");
    // back-to-back queries, other code first
    @(posedge clk);
    i_pipe.issue(32'h7, 1'b0);
    i_pipe.issue(32'h1, 1'b1);
    nq += 2;
    @(negedge clk);
    chk(c_out, EXP_C, "second of pair");
    rdchk(CFFR_OFS_COUNT, 32'(nq));
    $display("burst test done");
    // reset in mid-run clears results, count and function select
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({31'h0, ans} | d_out | c_out, 32'h0, "mid reset outputs");
    rdchk(CFFR_OFS_COUNT, 32'h0);
    rdchk(CFFR_OFS_FUNC_SEL, 32'h0);
    @(posedge clk);
    i_pipe.issue(32'h1, 1'b1);
    @(negedge clk);
    chk(d_out, EXP_D, "query after reset");
    $display("mid reset test done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
